// [dsc_pkg.sv]
// Purpose: shared constants and types for the disk sequencer control-word decoder
// Assumes: control store sits at 0xA0 (control bytes) and 0xC0 (count bytes)
// Notes: bit positions of the control byte are carried by the dsc_ctrl_t layout

package dsc_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] CTRL_BASE = 8'hA0;
   localparam logic [7:0] COUNT_BASE = 8'hC0;
   localparam logic [2:0] CTRL_PAGE = 3'h5;     // CTRL_BASE[7:5]
   localparam logic [2:0] COUNT_PAGE = 3'h6;    // COUNT_BASE[7:5]
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // ****************************************************************
   // sequencer geometry
   // ****************************************************************
   localparam int ADDR_W = 5;
   localparam int NUM_WORDS = 31;
   localparam logic [4:0] STOP_ADDR = 5'h1F;
   localparam logic [4:0] ADDR_RESET = 5'h1F;
   localparam int BYTE_BITS = 8;
   localparam int STACK_DEPTH = 8;
   localparam logic [2:0] PTR_RESET = 3'h0;

   // control byte, bit 7 down to bit 0
   typedef struct packed {
      logic setWriteGate;
      logic setReadLine;
      logic clearWriteGate;
      logic stackEnable;
      logic invalidInput;
      logic syncOutput;
      logic compareEnable;
      logic byteTransfer;
   } dsc_ctrl_t;

   // one byte access toward buffer memory
   typedef struct packed {
      logic req;
      logic write;
      logic [7:0] data;
   } dsc_buf_t;

   typedef enum logic [3:0] {
      ST_STOP = 4'b0001,
      ST_FETCH = 4'b0010,
      ST_LOAD = 4'b0100,
      ST_RUN = 4'b1000
   } dsc_state_t;

endpackage

// [dsc_store_ram.sv]
// Purpose: one byte plane of the microcode store, one write port and two read ports
// Assumes: read data are registered; out-of-range addresses read as zero
// Notes: no reset on the array, software loads it before starting the sequencer

`timescale 1ns/1ns

module dsc_store_ram #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 31,
   parameter int AW = 5
) (
   // clocking
   input wire logic clock,
   input wire logic ce,
   // write port
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   // read ports
   input wire logic [AW-1:0] rdAddrA,
   output logic [WIDTH-1:0] rdDataA,
   input wire logic [AW-1:0] rdAddrB,
   output logic [WIDTH-1:0] rdDataB
);

   logic [WIDTH-1:0] mem [DEPTH];
   wire inRangeA = (rdAddrA < AW'(DEPTH));
   wire inRangeB = (rdAddrB < AW'(DEPTH));
   wire inRangeW = (wrAddr < AW'(DEPTH));

   // write and both reads share the clock enable so a frozen block stays consistent
   always_ff @(posedge clock) begin
      if (ce) begin
         if (wrEn && inRangeW) begin
            mem[wrAddr] <= wrData;
         end
         rdDataA <= inRangeA ? mem[rdAddrA] : '0;
         rdDataB <= inRangeB ? mem[rdAddrB] : '0;
      end
   end

endmodule

// [dsc_serdes.sv]
// Purpose: byte serializer and deserializer for the nrz line with a byte-time tick
// Assumes: one clock per bit; nrzIn is already synchronised
// Notes: while idle the transmit shifter keeps reloading so the first byte is ready

`timescale 1ns/1ns

module dsc_serdes #(
   parameter int BITS = 8
) (
   // clocking
   input wire logic clock,
   input wire logic reset,
   input wire logic ce,
   // control
   input wire logic run,
   input wire logic txEnable,
   // data
   input wire logic [BITS-1:0] txByte,
   input wire logic nrzIn,
   output logic nrzOut,
   output logic [BITS-1:0] rxByte,
   output logic byteTick
);

   logic [$clog2(BITS)-1:0] bitCnt_reg;
   logic [BITS-1:0] txShift_reg;
   logic [BITS-1:0] rxShift_reg;
   wire lastBit = (bitCnt_reg == ($clog2(BITS))'(BITS - 1));

   // bit counter and tick; the tick marks the last bit of each byte time
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         bitCnt_reg <= '0;
         byteTick <= 1'b0;
      end else if (ce) begin
         bitCnt_reg <= run ? bitCnt_reg + 1'b1 : '0;
         byteTick <= run && lastBit;
      end
   end

   // shifters, msb first on the line
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         txShift_reg <= '0;
         rxShift_reg <= '0;
         rxByte <= '0;
         nrzOut <= 1'b0;
      end else if (ce) begin
         txShift_reg <= (!run || lastBit) ? txByte : {txShift_reg[BITS-2:0], 1'b0};
         rxShift_reg <= {rxShift_reg[BITS-2:0], nrzIn};
         if (run && lastBit) begin
            rxByte <= {rxShift_reg[BITS-2:0], nrzIn};
         end
         nrzOut <= run && txEnable && txShift_reg[BITS-1];
      end
   end

endmodule

// [dsc_control_word.sv]
// Purpose: decode of each sequencer word's control and count bytes into gates and transfers
// Assumes: next-address, branch, ecc and buffer arbitration live outside this block
// Notes: a word with count N runs N+1 byte times; the last is the one at count zero
// Overview of operation
// [RULE_01] with the transfer bit set, the count byte is a plain eight-bit byte counter
// [RULE_02] each transfer byte time accesses buffer memory unless the bypass bit is set
// [RULE_03] write gate on: serialize buffer byte, or data byte when bypassed, onto nrz
// [RULE_04] read gate on: deserialize nrz byte, store to buffer only when not bypassed
// [RULE_05] compare bit with read gate compares read bytes to data byte or buffer
// [RULE_06] the sync output pin follows the output bit of the executing word
// [RULE_07] invalid-input bit with read gate on makes the block ignore nrz input
// [RULE_08] stack bit pushes each read byte onto an eight-entry recirculating stack
// [RULE_09] clear-write-gate bit drops the write gate on the final count of the word
// [RULE_10] entering the stopped state drops the write gate
// [RULE_11] a word with set-read-gate raises the read gate when executed
// [RULE_12] read gate drops at end of ecc or on stop, whichever first
// [RULE_13] read gate is never raised while the write gate is up
// [RULE_14] set-write-gate raises write gate until a clearing word completes or stop
// [RULE_15] write gate is never raised while the read gate is up
// [RULE_16] each new word loads the down counter with its count byte
// [RULE_17] fetching address 1F stops the sequencer; 00 to 1E are executable
// [RULE_18] the microcontroller writes the store only while the sequencer cannot read it; this block takes store writes in any state
// [RULE_19] the word's control bits hold for all its byte times until next fetch

`timescale 1ns/1ns

module dsc_control_word #(
   parameter int DEPTH = 31,
   parameter int STACK = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   input wire logic ce,
   // microcontroller access to the store
   input wire logic [7:0] mcAddr,
   input wire logic mcWrite,
   input wire logic mcRead,
   input wire logic [7:0] mcWrData,
   output logic [7:0] mcRdData,
   output logic mcRdValid,
   // sequencer control from surrounding logic
   input wire logic startPulse,
   input wire logic [4:0] startAddr,
   input wire logic [4:0] nextAddr,
   input wire logic eccDone,
   input wire logic bufferBypassBit,
   input wire logic bufferPatternSelectBit,
   input wire logic [7:0] dataFieldByte,
   // buffer memory
   input wire logic [7:0] bufRdData,
   output dsc_pkg::dsc_buf_t bufAccess,
   // drive pins
   input wire logic nrzIn,
   output logic nrzOut,
   output logic nrzOutEnable,
   output logic writeGate,
   output logic readLineOn,
   output logic syncOut,
   // status
   output logic [4:0] seqAddr,
   output logic stopped,
   output logic compareNotEqual,
   output logic [7:0] stackTop
);

   // ****************************************************************
   // state and storage
   // ****************************************************************
   dsc_pkg::dsc_state_t state_reg;
   dsc_pkg::dsc_ctrl_t ctrl_reg;
   logic [7:0] countRem_reg;
   logic nrzMeta_reg;
   logic nrzSync_reg;
   logic rdPending_reg;
   logic rdSelCount_reg;
   logic rdMapped_reg;
   logic [2:0] pushPtr_reg;
   logic [7:0] stack_reg [STACK];
   logic [7:0] ctrlRdA;
   logic [7:0] countRdA;
   logic [7:0] ctrlRdB;
   logic [7:0] countRdB;
   logic [7:0] rxByte;
   logic byteTick;

   // ****************************************************************
   // decode
   // ****************************************************************
   wire inStop = (state_reg == dsc_pkg::ST_STOP);
   wire inFetch = (state_reg == dsc_pkg::ST_FETCH);
   wire inLoad = (state_reg == dsc_pkg::ST_LOAD);
   wire inRun = (state_reg == dsc_pkg::ST_RUN);
   wire wordInRange = (mcAddr[4:0] != dsc_pkg::STOP_ADDR);
   wire ctrlHit = (mcAddr[7:5] == dsc_pkg::CTRL_PAGE) && wordInRange;
   wire countHit = (mcAddr[7:5] == dsc_pkg::COUNT_PAGE) && wordInRange;
   // the store is written whenever asked; software must keep off the executing word
   wire ctrlWr = mcWrite && ctrlHit;   // [RULE_18]
   wire countWr = mcWrite && countHit;
   // word address presented to the store one cycle before its load
   wire [4:0] fetchAddr = inStop ? startAddr : (inFetch ? nextAddr : seqAddr);
   wire stopNow = inFetch && (nextAddr == dsc_pkg::STOP_ADDR);   // [RULE_17]
   wire startGo = inStop && startPulse && (startAddr != dsc_pkg::STOP_ADDR);
   dsc_pkg::dsc_ctrl_t ctrlNew;
   assign ctrlNew = dsc_pkg::dsc_ctrl_t'(ctrlRdB);
   // gate interlocks; a word asking for both gates gets only the write gate, or only the read gate if that is already up
   wire wgSet = inLoad && ctrlNew.setWriteGate && !readLineOn;   // [RULE_14] [RULE_15]
   wire rlSet = inLoad && ctrlNew.setReadLine && !writeGate && !wgSet;   // [RULE_11] [RULE_13]
   // byte-time events of the running word
   wire byteEnd = inRun && byteTick;
   wire finalByte = byteEnd && (countRem_reg == 8'h00);
   wire rxUsable = readLineOn && !ctrl_reg.invalidInput;   // [RULE_07]
   wire xferByte = byteEnd && ctrl_reg.byteTransfer;
   wire bufReq = xferByte && !bufferBypassBit;   // [RULE_02]
   wire bufWr = bufReq && rxUsable;   // [RULE_04]
   wire [7:0] txByte = bufferBypassBit ? dataFieldByte : bufRdData;   // [RULE_03]
   wire [7:0] cmpRef = bufferPatternSelectBit ? bufRdData : dataFieldByte;
   wire cmpMiss = byteEnd && ctrl_reg.compareEnable && rxUsable && (rxByte != cmpRef);   // [RULE_05]
   wire pushByte = byteEnd && ctrl_reg.stackEnable && rxUsable;   // [RULE_08]
   wire wgClear = inStop || stopNow || (finalByte && ctrl_reg.clearWriteGate);   // [RULE_09] [RULE_10]
   wire rlClear = inStop || stopNow || eccDone;   // [RULE_12]

   // ****************************************************************
   // control store planes
   // ****************************************************************
   dsc_store_ram #(.WIDTH(8), .DEPTH(DEPTH), .AW(dsc_pkg::ADDR_W)) ctrlStore (
      .clock(clock),
      .ce(ce),
      .wrEn(ctrlWr),
      .wrAddr(mcAddr[4:0]),
      .wrData(mcWrData),
      .rdAddrA(mcAddr[4:0]),
      .rdDataA(ctrlRdA),
      .rdAddrB(fetchAddr),
      .rdDataB(ctrlRdB)
   );
   dsc_store_ram #(.WIDTH(8), .DEPTH(DEPTH), .AW(dsc_pkg::ADDR_W)) countStore (
      .clock(clock),
      .ce(ce),
      .wrEn(countWr),
      .wrAddr(mcAddr[4:0]),
      .wrData(mcWrData),
      .rdAddrA(mcAddr[4:0]),
      .rdDataA(countRdA),
      .rdAddrB(fetchAddr),
      .rdDataB(countRdB)
   );

   // ****************************************************************
   // nrz line
   // ****************************************************************
   // the nrz pin is asynchronous to this clock, two flops before use
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         nrzMeta_reg <= 1'b0;
         nrzSync_reg <= 1'b0;
      end else if (ce) begin
         nrzMeta_reg <= nrzIn;
         nrzSync_reg <= nrzMeta_reg;
      end
   end

   // shifting runs for every byte time of the word, transfer bit or not
   dsc_serdes #(.BITS(dsc_pkg::BYTE_BITS)) serdes (
      .clock(clock),
      .reset(reset),
      .ce(ce),
      .run(inRun),
      .txEnable(writeGate),   // [RULE_03]
      .txByte(txByte),
      .nrzIn(nrzSync_reg),
      .nrzOut(nrzOut),
      .rxByte(rxByte),
      .byteTick(byteTick)
   );

   // ****************************************************************
   // sequencer word execution
   // ****************************************************************
   // state walk: stop, load, run per byte, fetch next, and back
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_reg <= dsc_pkg::ST_STOP;
         seqAddr <= dsc_pkg::ADDR_RESET;
      end else if (ce) begin
         case (state_reg)
            dsc_pkg::ST_STOP: begin
               if (startGo) begin
                  seqAddr <= startAddr;
                  state_reg <= dsc_pkg::ST_LOAD;
               end
            end
            dsc_pkg::ST_FETCH: begin
               seqAddr <= nextAddr;
               state_reg <= stopNow ? dsc_pkg::ST_STOP : dsc_pkg::ST_LOAD;   // [RULE_17]
            end
            dsc_pkg::ST_LOAD: begin
               state_reg <= dsc_pkg::ST_RUN;
            end
            dsc_pkg::ST_RUN: begin
               if (finalByte) begin
                  state_reg <= dsc_pkg::ST_FETCH;
               end
            end
            default: begin
               state_reg <= dsc_pkg::ST_STOP;
            end
         endcase
      end
   end

   // the word is latched once and held; a store write cannot disturb a running word
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ctrl_reg <= dsc_pkg::dsc_ctrl_t'(dsc_pkg::CTRL_RESET);
         countRem_reg <= dsc_pkg::COUNT_RESET;
      end else if (ce) begin
         if (inLoad) begin
            ctrl_reg <= ctrlNew;   // [RULE_19]
            countRem_reg <= countRdB;   // [RULE_16]
         end else if (byteEnd && !finalByte) begin
            countRem_reg <= countRem_reg - 8'h01;   // [RULE_01]
         end
      end
   end

   // ****************************************************************
   // gates and pins
   // ****************************************************************
   // a set in the same cycle as an ecc-done clear wins; stop always clears
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         writeGate <= 1'b0;
         nrzOutEnable <= 1'b0;
         readLineOn <= 1'b0;
      end else if (ce) begin
         writeGate <= wgSet || (writeGate && !wgClear);   // [RULE_14]
         nrzOutEnable <= wgSet || (writeGate && !wgClear);
         readLineOn <= rlSet || (readLineOn && !rlClear);   // [RULE_11] [RULE_12]
      end
   end

   // sync pin and stopped flag follow the state of the store walk
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         syncOut <= 1'b0;
         stopped <= 1'b1;
      end else if (ce) begin
         syncOut <= inLoad ? ctrlNew.syncOutput : (ctrl_reg.syncOutput && !stopNow && !inStop);   // [RULE_06]
         stopped <= stopNow || (inStop && !startGo);
      end
   end

   // ****************************************************************
   // buffer, compare and stack
   // ****************************************************************
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         bufAccess <= '0;
         compareNotEqual <= 1'b0;
      end else if (ce) begin
         bufAccess.req <= bufReq;   // [RULE_02]
         bufAccess.write <= bufWr;   // [RULE_04]
         bufAccess.data <= rxByte;
         // a miss is kept for the word; a new word starts clean
         compareNotEqual <= cmpMiss || (compareNotEqual && !inLoad);   // [RULE_05]
      end
   end

   // the stack overwrites its oldest entry once full, no overflow flag
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pushPtr_reg <= dsc_pkg::PTR_RESET;
         stackTop <= 8'h00;
      end else if (ce && pushByte) begin
         pushPtr_reg <= pushPtr_reg + 3'h1;   // [RULE_08]
         stackTop <= rxByte;
      end
   end
   for (genvar i = 0; i < STACK; i++) begin : gStack
      always_ff @(posedge clock or posedge reset) begin
         if (reset) begin
            stack_reg[i] <= 8'h00;
         end else if (ce && pushByte && (pushPtr_reg == 3'(i))) begin
            stack_reg[i] <= rxByte;   // [RULE_08]
         end
      end
   end

   // ****************************************************************
   // microcontroller read-back
   // ****************************************************************
   // two cycles from request to data: store read, then select
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rdPending_reg <= 1'b0;
         rdSelCount_reg <= 1'b0;
         rdMapped_reg <= 1'b0;
         mcRdData <= 8'h00;
         mcRdValid <= 1'b0;
      end else if (ce) begin
         rdPending_reg <= mcRead;
         rdSelCount_reg <= countHit;
         rdMapped_reg <= ctrlHit || countHit;
         mcRdValid <= rdPending_reg;
         if (rdPending_reg) begin
            mcRdData <= !rdMapped_reg ? dsc_pkg::UNMAPPED_READ : (rdSelCount_reg ? countRdA : ctrlRdA);
         end
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   a_gates_exclusive: assert property (@(posedge clock) disable iff (reset) // [RULE_13] [RULE_15]
      !(writeGate && readLineOn)) else $error("read and write gates both active");
   a_stop_gates_off: assert property (@(posedge clock) disable iff (reset) // [RULE_10]
      inStop |-> (!writeGate && !readLineOn)) else $error("gate active while stopped");
   a_sync_follow: assert property (@(posedge clock) disable iff (reset) // [RULE_06]
      inRun |-> (syncOut == ctrl_reg.syncOutput)) else $error("sync pin differs from word");
   a_buf_bypass: assert property (@(posedge clock) disable iff (reset) // [RULE_02]
      (ce && bufferBypassBit) |=> !bufAccess.req) else $error("buffer accessed while bypassed");
   a_read_store: assert property (@(posedge clock) disable iff (reset) // [RULE_04]
      (ce && bufReq && rxUsable) |=> (bufAccess.req && bufAccess.write)) else $error("read byte not stored");
   a_invalid_block: assert property (@(posedge clock) disable iff (reset) // [RULE_07]
      (ce && ctrl_reg.invalidInput) |=> (!bufAccess.write && $stable(pushPtr_reg)))
      else $error("nrz input used while marked invalid");
   a_count_load: assert property (@(posedge clock) disable iff (reset) // [RULE_16]
      (ce && inLoad) |=> (countRem_reg == $past(countRdB))) else $error("counter not loaded");
   a_stop_fetch: assert property (@(posedge clock) disable iff (reset) // [RULE_17]
      (ce && stopNow) |=> (inStop && stopped && !writeGate)) else $error("1F fetch did not stop");
   a_word_hold: assert property (@(posedge clock) disable iff (reset) // [RULE_19]
      (inRun && $past(inRun)) |-> $stable(ctrl_reg)) else $error("control bits changed mid word");
   a_wg_final_clear: assert property (@(posedge clock) disable iff (reset) // [RULE_09]
      (ce && finalByte && ctrl_reg.clearWriteGate) |=> !writeGate) else $error("write gate held");
   a_stack_push: assert property (@(posedge clock) disable iff (reset) // [RULE_08]
      (ce && pushByte) |=> (stack_reg[pushPtr_reg - 3'h1] == stackTop)) else $error("stack entry not pushed");
endmodule

// [dsc_drive_model.sv]
// Purpose: behavioural drive channel facing the nrz and gate pins
// Assumes: read data is a run of ones, so byte alignment cannot matter
// Notes: a released line toggles every cycle so a stale level never looks valid
`timescale 1ns/1ns
module dsc_drive_model (
   // clocking
   input wire logic clock,
   // gates and data from the block
   input wire logic readLineOn,
   input wire logic nrzOut,
   input wire logic nrzOutEnable,
   // data toward the block
   output logic nrzIn,
   output int onesSeen
);
   // ****************************************************************
   // read head and write head
   // ****************************************************************
   initial nrzIn = 1'b0;
   initial onesSeen = 0;
   // media gives ones under the read gate and toggles otherwise; written ones are counted
   always @(posedge clock) begin
      nrzIn <= readLineOn ? 1'b1 : ~nrzIn;
      if (nrzOutEnable === 1'b1 && nrzOut === 1'b1) begin
         onesSeen <= onesSeen + 1;
      end
   end
endmodule

// [tb.sv]
// Purpose: self-checking bench for the sequencer control-word decoder
// Assumes: store words are written only while the sequencer is stopped
// Notes: activity counters run only while the sequencer is not stopped
`timescale 1ns/1ns
module tb;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [7:0] mcAddr = 8'h00, mcWrData = 8'h00, dataFieldByte = 8'h00, bufRdData = 8'hFF;
   logic mcWrite = 1'b0, mcRead = 1'b0, startPulse = 1'b0, eccDone = 1'b0, bypass = 1'b0, psel = 1'b0;
   logic [4:0] startAddr = 5'h00, nextAddr = 5'h1F, lastW = 5'h00;
   logic [7:0] mcRdData, stackTop, reqs, wrs;
   logic mcRdValid, nrzIn, nrzOut, nrzOutEnable, writeGate, readLineOn, syncOut, stopped, cne;
   logic rlSeen, wgSeen, cneSeen, wg3;
   logic [4:0] seqAddr;
   dsc_pkg::dsc_buf_t bufAccess;
   int onesSeen, ones0, syncCnt, error_cnt = 0, n_compared = 0;
   dsc_control_word dsc_control_word_inst (.clock(clock), .reset(reset), .ce(1'b1), .mcAddr(mcAddr),
      .mcWrite(mcWrite), .mcRead(mcRead), .mcWrData(mcWrData), .mcRdData(mcRdData), .mcRdValid(mcRdValid),
      .startPulse(startPulse), .startAddr(startAddr), .nextAddr(nextAddr), .eccDone(eccDone),
      .bufferBypassBit(bypass), .bufferPatternSelectBit(psel), .dataFieldByte(dataFieldByte),
      .bufRdData(bufRdData), .bufAccess(bufAccess), .nrzIn(nrzIn), .nrzOut(nrzOut),
      .nrzOutEnable(nrzOutEnable), .writeGate(writeGate), .readLineOn(readLineOn), .syncOut(syncOut),
      .seqAddr(seqAddr), .stopped(stopped), .compareNotEqual(cne), .stackTop(stackTop));
   dsc_drive_model dsc_drive_model_inst (.clock(clock), .readLineOn(readLineOn), .nrzOut(nrzOut),
      .nrzOutEnable(nrzOutEnable), .nrzIn(nrzIn), .onesSeen(onesSeen));
   // ****************************************************************
   // clock, branch stand-in and activity monitor
   // ****************************************************************
   always #5 clock = ~clock;
   // words run in address order up to lastW, then the stop address
   always @(negedge clock) nextAddr <= (seqAddr >= lastW) ? 5'h1F : seqAddr + 5'h01;
   // gather what each run did at the pins
   always @(posedge clock) begin
      if (stopped === 1'b0) begin
         reqs <= reqs + {7'h00, bufAccess.req};
         wrs <= wrs + {7'h00, bufAccess.req & bufAccess.write & (bufAccess.data == 8'hFF)};
         rlSeen <= rlSeen | readLineOn;
         wgSeen <= wgSeen | writeGate;
         cneSeen <= cneSeen | cne;
         wg3 <= wg3 | (writeGate & (seqAddr == 5'h03));
         syncCnt <= syncCnt + int'(syncOut);
      end
   end
   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      mcAddr = a;
      mcWrData = d;
      mcWrite = 1'b1;
      @(negedge clock);
      mcWrite = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      int n;
      n = 0;
      @(negedge clock);
      mcAddr = a;
      mcRead = 1'b1;
      @(negedge clock);
      mcRead = 1'b0;
      while (mcRdValid !== 1'b1 && n < 5) begin
         @(negedge clock);
         n++;
      end
      chk({mcRdValid, 7'h00}, 8'h80);
      chk(mcRdData, e);
   endtask
   task automatic prog(input logic [4:0] w, input logic [7:0] c, input logic [7:0] n);
      wr(8'hA0 + {3'h0, w}, c);
      wr(8'hC0 + {3'h0, w}, n);
   endtask
   task automatic go(input logic [4:0] last, input logic [4:0] first);
      lastW = last;
      {reqs, wrs, rlSeen, wgSeen, cneSeen, wg3, syncCnt, ones0} = {16'h0000, 4'h0, 32'd0, onesSeen};
      @(negedge clock);
      startAddr = first;
      startPulse = 1'b1;
      @(negedge clock);
      startPulse = 1'b0;
   endtask
   task automatic wait_stop();
      int n;
      n = 0;
      @(negedge clock);
      while (stopped !== 1'b1 && n < 600) begin
         @(negedge clock);
         n++;
      end
      chk({stopped, writeGate, readLineOn, 5'h00}, 8'h80);
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   // bounded by far more than the scenarios need, 20000 cycles
   initial begin
      #200000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge clock);
      @(negedge clock);
      reset = 1'b0;
      chk({stopped, seqAddr, writeGate, readLineOn}, 8'hFC);
      wr(8'hA3, 8'h5A);
      wr(8'hC3, 8'h3C);
      wr(8'hBF, 8'h77);
      rd(8'hA3, 8'h5A);
      rd(8'hC3, 8'h3C);
      rd(8'hBF, 8'h00);
      // write sequence: long set-write word, refused read gate, clearing word, idle word
      prog(5'h00, 8'h85, 8'h04);
      prog(5'h01, 8'h40, 8'h00);
      prog(5'h02, 8'h21, 8'h00);
      prog(5'h03, 8'h00, 8'h03);
      go(5'h03, 5'h00);
      wait_stop();
      chk(reqs, 8'h06);
      chk({wgSeen, rlSeen, wg3, wrs[4:0]}, 8'h80);
      chk({7'h00, (onesSeen - ones0) >= 40}, 8'h01);
      chk({7'h00, syncCnt >= 40 && syncCnt <= 43}, 8'h01);
      // bypassed write sends the data byte and touches no buffer
      bypass = 1'b1;
      dataFieldByte = 8'h00;
      prog(5'h00, 8'h81, 8'h01);
      go(5'h00, 5'h00);
      wait_stop();
      chk({reqs[6:0], wgSeen}, 8'h01);
      chk(8'(onesSeen - ones0), 8'h00);
      // read sequence over three compare set-ups: miss, data hit, buffer hit
      bypass = 1'b0;
      prog(5'h00, 8'h40, 8'h00);
      prog(5'h01, 8'h53, 8'h01);
      prog(5'h02, 8'h89, 8'h00);
      for (int i = 0; i < 3; i++) begin
         {dataFieldByte, psel, bufRdData} = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1FE00 : 17'h001FF;
         go(5'h02, 5'h00);
         wait_stop();
         chk({reqs[3:0], wrs[3:0]}, 8'h32);
         chk({rlSeen, wgSeen, cneSeen, 5'h00}, (i == 0) ? 8'hA0 : 8'h80);
         chk(stackTop, 8'hFF);
      end
      // end of ecc drops the read gate mid-word
      prog(5'h00, 8'h40, 8'h07);
      go(5'h00, 5'h00);
      repeat (30) @(negedge clock);
      chk({readLineOn, stopped, 6'h00}, 8'h80);
      eccDone = 1'b1;
      @(negedge clock);
      eccDone = 1'b0;
      @(negedge clock);
      chk({readLineOn, stopped, 6'h00}, 8'h00);
      wait_stop();
      // starting at the stop address leaves the block stopped
      go(5'h00, 5'h1F);
      repeat (4) @(negedge clock);
      chk({stopped, seqAddr, 2'h0}, 8'hFC);
      report_and_stop();
   end
endmodule
